// ==== inc/fmlr_regs.svh ====
// Purpose: constants of the motor fault latch and report block
// Assumes: 20 MHz clock, codes carried in 8 bits
// Notes:   definitions only
`ifndef FMLR_REGS_SVH
`define FMLR_REGS_SVH

// ----------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------
`define FMLR_CODE_W        8
`define FMLR_SEC_W         32
`define FMLR_SLOTS         19
`define FMLR_HIST_DEPTH    16
`define FMLR_HIST_AW       4
`define FMLR_CNT_W         5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FMLR_CLK_PERIOD_NS 50
`define FMLR_SECOND_NS     1000000000
`define FMLR_SEC_TICKS     (`FMLR_SECOND_NS / `FMLR_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// slot layout: slots 0..13 carry codes 0..13, 14..18 carry 80..84
// ----------------------------------------------------------------
`define FMLR_DETAIL_BASE   8'h50
`define FMLR_FIRST_DETAIL  14
`define FMLR_PROT_MASK     19'h0_3F3F
`define FMLR_FO_RELAY      0
`define FMLR_FO_LAMP       1
`define FMLR_CB_DET_W      3
`define FMLR_WIRE_DET_W    2
`endif

// ==== inc/fmlr_pkg.sv ====
// Purpose: shared types of the motor fault latch and report block
// Assumes: constants come from fmlr_regs.svh
// Notes:   none
`include "fmlr_regs.svh"
package fmlr_pkg;
    // live conditions from the detection logic, same clock
    typedef struct packed {
        logic                         earthWarn;
        logic                         earthTrip;
        logic                         highWarn;
        logic                         highTrip;
        logic                         lowWarn;
        logic                         lowTrip;
        logic [`FMLR_WIRE_DET_W-1:0]  wireDet;
        logic [`FMLR_CB_DET_W-1:0]    checkBackDet;
        logic                         thermistorHot;
        logic                         thermWarn;
        logic                         lockedRotor;
        logic                         phaseImb;
        logic                         phaseLoss;
        logic                         thermTrip;
    } fmlr_cond_t;

    // one history entry or diagnosis message
    typedef struct packed {
        logic [`FMLR_CODE_W-1:0] code;
        logic [`FMLR_SEC_W-1:0]  secs;
    } fmlr_hist_t;
endpackage

// ==== core/fmlr_sec_timer.sv ====
// Purpose: seconds since power on
// Assumes: rst is the power-on reset
// Notes:   ticks is a parameter so simulation can shorten a second
`timescale 1ns/1ns
`include "fmlr_regs.svh"
module fmlr_sec_timer #(
    parameter int unsigned TICKS = `FMLR_SEC_TICKS
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    output logic [`FMLR_SEC_W-1:0]      seconds
);
    logic [31:0] preReg;
    wire         secTick = (preReg == 32'(TICKS - 1));

    // ----------------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------------
    // cleared at power on
    always_ff @(posedge clk) begin
        if (rst) begin
            preReg  <= 32'h0000_0000;
            seconds <= 32'h0000_0000;
        end else begin
            preReg  <= secTick ? 32'h0000_0000 : preReg + 32'h0000_0001;
            seconds <= secTick ? seconds + 32'h0000_0001 : seconds;
        end
    end

    property p_secStep;
        @(posedge clk) disable iff (rst) !secTick |=> seconds == $past(seconds);
    endproperty
    a_secStep: assert property (p_secStep) else $error("seconds moved without a tick");
endmodule

// ==== core/fmlr_hist_mem.sv ====
// Purpose: 16-entry fault history storage
// Assumes: one write and one read per cycle
// Notes:   read data is registered; invalid entries read as zero
`timescale 1ns/1ns
`include "fmlr_regs.svh"
module fmlr_hist_mem (
    input  wire logic                        clk,
    input  wire logic                        wrEn,
    input  wire logic [`FMLR_HIST_AW-1:0]    wrAddr,
    input  wire fmlr_pkg::fmlr_hist_t        wrData,
    input  wire logic [`FMLR_HIST_AW-1:0]    rdAddr,
    input  wire logic                        rdValid,
    output fmlr_pkg::fmlr_hist_t             rdData
);
    fmlr_pkg::fmlr_hist_t store [`FMLR_HIST_DEPTH];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // no reset on the array: emptiness lives in the entry count outside
    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
        rdData <= rdValid ? store[rdAddr] : '0;
    end
endmodule

// ==== core/fmlr_core.sv ====
// Purpose: latch, acknowledge, record and report motor protection faults
// Assumes: fault conditions arrive from detection logic on clk
// Notes:   multifunction inputs are pins and pass a synchroniser
//
// What this block does
// - detected fault sets a latched indication
// - latch holds until an acknowledge arrives
// - auto acknowledge off by default after reset
// - acknowledge from panel, fieldbus, configured inputs
// - auto acknowledge clears trips once condition ends
// - history of last 16 faults with seconds
// - history and seconds cleared at power up
// - relay and lamp outputs drive summary fault
// - fault lamp on until fault acknowledged
// - fieldbus fault flag one while a fault is latched
// - diagnosis message only where fieldbus supports it
// - thermal trip code 0, warning code 4
// - phase loss code 1, imbalance code 2
// - locked rotor code 3
// - thermistor overtemperature code 5
// - codes 6 and 7 summarise detail codes
// - low current trip 8, warning 9
// - high current trip 10, warning 11
// - earth fault trip 12, warning 13
`timescale 1ns/1ns
`include "fmlr_regs.svh"
module fmlr_core #(
    parameter int unsigned SEC_TICKS = `FMLR_SEC_TICKS
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire fmlr_pkg::fmlr_cond_t        cond,
    input  wire logic                        panelAck,
    input  wire logic                        busAck,
    input  wire logic [2:0]                  multifunction_inputs,
    input  wire logic [2:0]                  mfAckCfg,
    input  wire logic                        autoAckEn,
    input  wire logic [1:0]                  faultOutCfg,
    input  wire logic                        diagSupported,
    input  wire logic [`FMLR_HIST_AW-1:0]    histRdIdx,
    output logic                             relay_alarm_output,
    output logic                             lamp_drive_output,
    output logic                             faultLed,
    output logic                             busFaultBit,
    output logic [`FMLR_SLOTS-1:0]           latchedFaults,
    output logic                             diagValid,
    output fmlr_pkg::fmlr_hist_t             diagMsg,
    output logic [`FMLR_CNT_W-1:0]           histCount,
    output logic                             histRdValid,
    output fmlr_pkg::fmlr_hist_t             histRdData,
    output logic [`FMLR_SEC_W-1:0]           secondsNow
);
    // ----------------------------------------------------------------
    // slot to code
    // ----------------------------------------------------------------
    function automatic logic [`FMLR_CODE_W-1:0] slotCode(input logic [4:0] slot);
        logic [`FMLR_CODE_W-1:0] c;
        c = 8'h00;
        if (slot < 5'(`FMLR_FIRST_DETAIL)) begin
            c = {3'h0, slot};
        end else begin
            c = `FMLR_DETAIL_BASE + {3'h0, slot - 5'(`FMLR_FIRST_DETAIL)};
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0]                 mfSync1_reg;
    logic [2:0]                 mfSync2_reg;
    logic [2:0]                 mfPrev_reg;
    logic [2:0]                 mfAckCfg_reg;
    logic                       autoAck_reg;
    logic [1:0]                 faultOutCfg_reg;
    logic                       diagSup_reg;
    logic [`FMLR_SLOTS-1:0]     latch_reg;
    logic [`FMLR_SLOTS-1:0]     pend_reg;
    logic [`FMLR_HIST_AW-1:0]   wrPtr_reg;
    logic [`FMLR_SLOTS-1:0]     liveVec;
    logic [`FMLR_SLOTS-1:0]     clrVec;
    logic [`FMLR_SLOTS-1:0]     latch_next;
    logic [`FMLR_SLOTS-1:0]     newVec;
    logic [`FMLR_SLOTS-1:0]     pickHot;
    logic [`FMLR_SLOTS-1:0]     pend_next;
    logic [4:0]                 pickSlot;
    logic [2:0]                 mfRise;
    logic                       ackAny;
    logic                       anyLatched;
    logic                       histWr;
    logic                       rdValidNow;
    logic [`FMLR_HIST_AW-1:0]   rdAddr;
    fmlr_pkg::fmlr_hist_t       newEntry;

    // ----------------------------------------------------------------
    // seconds counter and history storage
    // ----------------------------------------------------------------
    fmlr_sec_timer #(
        .TICKS   (SEC_TICKS)
    ) uTimer (
        .clk     (clk),
        .rst     (rst),
        .seconds (secondsNow)
    );

    fmlr_hist_mem uMem (
        .clk     (clk),
        .wrEn    (histWr),
        .wrAddr  (wrPtr_reg),
        .wrData  (newEntry),
        .rdAddr  (rdAddr),
        .rdValid (rdValidNow),
        .rdData  (histRdData)
    );

    // ----------------------------------------------------------------
    // live condition vector
    // ----------------------------------------------------------------
    // summaries 6 and 7 follow their detail codes
    assign liveVec = {cond.wireDet,
                      cond.checkBackDet,
                      cond.earthWarn, cond.earthTrip,
                      cond.highWarn,  cond.highTrip,
                      cond.lowWarn,   cond.lowTrip,
                      |cond.checkBackDet,
                      |cond.wireDet,
                      cond.thermistorHot, cond.thermWarn,
                      cond.lockedRotor,   cond.phaseImb,
                      cond.phaseLoss,     cond.thermTrip};

    // ----------------------------------------------------------------
    // acknowledge sources
    // ----------------------------------------------------------------
    // rising edge of a configured input is an acknowledge
    assign mfRise = mfSync2_reg & ~mfPrev_reg & mfAckCfg_reg;
    // any of the three paths acknowledges
    assign ackAny = panelAck | busAck | (|mfRise);

    always_ff @(posedge clk) begin
        if (rst) begin
            mfSync1_reg <= 3'h0;
            mfSync2_reg <= 3'h0;
            mfPrev_reg  <= 3'h0;
        end else begin
            mfSync1_reg <= multifunction_inputs;
            mfSync2_reg <= mfSync1_reg;
            mfPrev_reg  <= mfSync2_reg;
        end
    end

    // ----------------------------------------------------------------
    // configuration
    // ----------------------------------------------------------------
    // auto acknowledge starts off after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            mfAckCfg_reg    <= 3'h0;
            autoAck_reg     <= 1'b0;
            faultOutCfg_reg <= 2'h0;
            diagSup_reg     <= 1'b0;
        end else begin
            mfAckCfg_reg    <= mfAckCfg;
            autoAck_reg     <= autoAckEn;
            faultOutCfg_reg <= faultOutCfg;
            diagSup_reg     <= diagSupported;
        end
    end

    // ----------------------------------------------------------------
    // latching
    // ----------------------------------------------------------------
    // auto clear only protection trips and warnings (codes 0..5, 8..13) whose condition is gone
    assign clrVec = {`FMLR_SLOTS{ackAny}}
                  | ({`FMLR_SLOTS{autoAck_reg}} & `FMLR_PROT_MASK & ~liveVec);
    // live condition sets, clear only by acknowledge or auto acknowledge; set wins
    assign latch_next = liveVec | (latch_reg & ~clrVec);
    assign newVec     = latch_next & ~latch_reg;
    assign anyLatched = |latch_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // ----------------------------------------------------------------
    // history queue
    // ----------------------------------------------------------------
    // faults arriving together are logged one per cycle, lowest code first
    assign pickHot   = pend_reg & (~pend_reg + 19'h0_0001);
    assign pend_next = (pend_reg & ~pickHot) | newVec;
    assign histWr    = |pend_reg;

    always_comb begin
        pickSlot = 5'h00;
        for (int i = `FMLR_SLOTS - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                pickSlot = 5'(i);
            end
        end
    end

    // code in an unsigned 8-bit field
    assign newEntry = '{code: slotCode(pickSlot), secs: secondsNow};

    // ring of 16, the oldest is overwritten
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_reg  <= '0;
            wrPtr_reg <= 4'h0;
            histCount <= 5'h00;
        end else begin
            pend_reg  <= pend_next;
            wrPtr_reg <= histWr ? wrPtr_reg + 4'h1 : wrPtr_reg;
            if (histWr && histCount != 5'(`FMLR_HIST_DEPTH)) begin
                histCount <= histCount + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // history read, index 0 is the newest
    // ----------------------------------------------------------------
    // entries beyond the count read as zero, so history starts empty
    assign rdAddr     = wrPtr_reg - 4'h1 - histRdIdx;
    assign rdValidNow = {1'b0, histRdIdx} < histCount;

    always_ff @(posedge clk) begin
        if (rst) begin
            histRdValid <= 1'b0;
        end else begin
            histRdValid <= rdValidNow;
        end
    end

    // ----------------------------------------------------------------
    // indication outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            relay_alarm_output <= 1'b0;
            lamp_drive_output  <= 1'b0;
            faultLed           <= 1'b0;
            busFaultBit        <= 1'b0;
            latchedFaults      <= '0;
        end else begin
            relay_alarm_output <= anyLatched & faultOutCfg_reg[`FMLR_FO_RELAY];
            lamp_drive_output  <= anyLatched & faultOutCfg_reg[`FMLR_FO_LAMP];
            // lamp follows the latch, not the live condition
            faultLed           <= anyLatched;
            busFaultBit        <= anyLatched;
            latchedFaults      <= latch_reg;
        end
    end

    // ----------------------------------------------------------------
    // diagnosis message
    // ----------------------------------------------------------------
    // one message per logged fault; dropped silently when unsupported
    always_ff @(posedge clk) begin
        if (rst) begin
            diagValid <= 1'b0;
            diagMsg   <= '0;
        end else begin
            diagValid <= histWr & diagSup_reg;
            diagMsg   <= histWr ? newEntry : diagMsg;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_latchSet;
        @(posedge clk) disable iff (rst)
        (liveVec != '0) |=> ((latch_reg & $past(liveVec)) == $past(liveVec));
    endproperty
    a_latchSet: assert property (p_latchSet) else $error("live fault not latched");

    property p_latchHold;
        @(posedge clk) disable iff (rst)
        (!ackAny && !autoAck_reg) |=> ((latch_reg & $past(latch_reg)) == $past(latch_reg));
    endproperty
    a_latchHold: assert property (p_latchHold) else $error("latch lost without acknowledge");

    property p_defaultManual;
        @(posedge clk) disable iff (rst)
        (!autoAck_reg && latch_reg[0] && !ackAny) |=> latch_reg[0];
    endproperty
    a_defaultManual: assert property (p_defaultManual) else $error("trip cleared without acknowledge");

    property p_autoOffAtReset;
        @(posedge clk) disable iff (rst)
        $past(rst) |-> !autoAck_reg;
    endproperty
    a_autoOffAtReset: assert property (p_autoOffAtReset) else $error("auto acknowledge on after reset");

    property p_ackClears;
        @(posedge clk) disable iff (rst)
        (ackAny && liveVec == '0) |=> (latch_reg == '0) ##1 (faultLed == 1'b0);
    endproperty
    a_ackClears: assert property (p_ackClears) else $error("acknowledge did not clear");

    property p_autoClear;
        @(posedge clk) disable iff (rst)
        (autoAck_reg && latch_reg[0] && !liveVec[0]) |=> !latch_reg[0];
    endproperty
    a_autoClear: assert property (p_autoClear) else $error("auto acknowledge failed");

    property p_histCount;
        @(posedge clk) disable iff (rst)
        (histWr && histCount < 5'(`FMLR_HIST_DEPTH)) |=> histCount == $past(histCount) + 5'h01;
    endproperty
    a_histCount: assert property (p_histCount) else $error("history count wrong");

    property p_powerUpEmpty;
        @(posedge clk) disable iff (rst)
        $past(rst) |-> (histCount == 5'h00 && secondsNow == 32'h0000_0000);
    endproperty
    a_powerUpEmpty: assert property (p_powerUpEmpty) else $error("history not empty at power up");

    property p_relay;
        @(posedge clk) disable iff (rst)
        (anyLatched && faultOutCfg_reg[`FMLR_FO_RELAY]) |=> relay_alarm_output;
    endproperty
    a_relay: assert property (p_relay) else $error("relay summary missing");

    property p_lamp;
        @(posedge clk) disable iff (rst)
        (liveVec != '0) |=> ##1 faultLed;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp late");

    property p_busFlag;
        @(posedge clk) disable iff (rst)
        (liveVec != '0) |=> ##1 busFaultBit;
    endproperty
    a_busFlag: assert property (p_busFlag) else $error("fault flag late");

    property p_diagGate;
        @(posedge clk) disable iff (rst)
        diagValid |-> ($past(diagSup_reg) && $past(histWr));
    endproperty
    a_diagGate: assert property (p_diagGate) else $error("diagnosis without support");

    property p_codeZero;
        @(posedge clk) disable iff (rst)
        (histWr && pickSlot == 5'h00 && diagSup_reg) |=> (diagValid && diagMsg.code == 8'h00);
    endproperty
    a_codeZero: assert property (p_codeZero) else $error("thermal trip code wrong");
endmodule

// ==== tb/fmlr_partner.sv ====
// Purpose: far side model: operator panel, fieldbus controller, acknowledge pins
// Assumes: the testbench asks for acknowledges through task ack
// Notes:   pins idle low; a pin is held 4 cycles so it survives the synchroniser
`timescale 1ns/1ns
module fmlr_partner (
    input  wire logic                 clk,
    input  wire logic                 diagValid,
    input  wire fmlr_pkg::fmlr_hist_t diagMsg,
    output logic                      panelAck,
    output logic                      busAck,
    output logic [2:0]                mfPins
);
    fmlr_pkg::fmlr_hist_t diagQ [$];

    initial begin
        panelAck = 1'b0;
        busAck = 1'b0;
        mfPins = 3'h0;
    end

    task automatic ack(input int path);
        @(posedge clk);
        if (path == 0) panelAck <= 1'b1;
        else if (path == 1) busAck <= 1'b1;
        else mfPins[path-2] <= 1'b1;
        repeat (4) @(posedge clk);
        panelAck <= 1'b0;
        busAck <= 1'b0;
        mfPins <= 3'h0;
    endtask

    always @(posedge clk) begin
        if (diagValid === 1'b1) begin
            diagQ.push_back(diagMsg);
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the fault latch and report block
// Assumes: a second is shortened to 10 clock cycles
// Notes:   one row per detected condition, awkward cases after the loop
`timescale 1ns/1ns
`include "fmlr_regs.svh"
module testbench;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    fmlr_pkg::fmlr_cond_t cond;
    logic [2:0]           mfAckCfg;
    logic                 autoAckEn;
    logic [1:0]           faultOutCfg;
    logic                 diagSupported;
    logic [3:0]           histRdIdx;
    logic                 panelAck, busAck, relayOut, lampOut, faultLed, busFaultBit, diagValid, histRdValid;
    logic [2:0]           mfPins;
    logic [18:0]          latchedFaults;
    logic [4:0]           histCount;
    logic [31:0]          secondsNow;
    fmlr_pkg::fmlr_hist_t diagMsg, histRdData, lastDiag;
    int                   mismatches = 0;
    int                   compares = 0;
    logic [7:0]           rowCode [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h07, 8'h07,
                                           8'h06, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};

    always #25 clk = ~clk;

    fmlr_core #(.SEC_TICKS(10)) i_fmlr_core (.clk(clk), .rst(rst), .cond(cond), .panelAck(panelAck),
        .busAck(busAck), .multifunction_inputs(mfPins), .mfAckCfg(mfAckCfg), .autoAckEn(autoAckEn),
        .faultOutCfg(faultOutCfg), .diagSupported(diagSupported), .histRdIdx(histRdIdx),
        .relay_alarm_output(relayOut), .lamp_drive_output(lampOut), .faultLed(faultLed),
        .busFaultBit(busFaultBit), .latchedFaults(latchedFaults), .diagValid(diagValid), .diagMsg(diagMsg),
        .histCount(histCount), .histRdValid(histRdValid), .histRdData(histRdData), .secondsNow(secondsNow));

    fmlr_partner i_fmlr_partner (.clk(clk), .diagValid(diagValid), .diagMsg(diagMsg),
        .panelAck(panelAck), .busAck(busAck), .mfPins(mfPins));

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // pulse one condition bit, or hold it when hold is set
    task automatic fault(input int b, input bit hold);
        @(posedge clk) cond <= fmlr_pkg::fmlr_cond_t'(1 << b);
        @(posedge clk) if (!hold) cond <= '0;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask

    function automatic logic [18:0] slotBit(input logic [7:0] c);
        return 19'h0_0001 << (c < 8'h0E ? c : c - 8'h42);
    endfunction

    initial begin
        #(6000 * 50);
        mismatches++;
        test_done();
    end

    initial begin
        logic [7:0]  c2;
        logic [18:0] expMask;
        cond          <= '0;
        mfAckCfg      <= 3'h7;
        autoAckEn     <= 1'b0;
        faultOutCfg   <= 2'h3;
        diagSupported <= 1'b1;
        histRdIdx     <= 4'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        check(latchedFaults, 19'h0_0000);
        check(histCount, 5'h00);
        check(secondsNow, 32'h0000_0000);
        $display("test reset done");
        for (int r = 0; r < 17; r++) begin
            c2 = (r >= 6 && r <= 10) ? 8'h4A + r : 8'hFF;
            expMask = slotBit(rowCode[r]) | (c2 != 8'hFF ? slotBit(c2) : 19'h0_0000);
            i_fmlr_partner.diagQ.delete();
            fault(r, 1'b0);
            settle();
            check(latchedFaults, expMask);
            check({faultLed, busFaultBit, relayOut, lampOut}, 4'hF);
            check(i_fmlr_partner.diagQ.size(), (c2 != 8'hFF) ? 2 : 1);
            lastDiag = i_fmlr_partner.diagQ.pop_front();
            check(lastDiag.code, rowCode[r]);
            if (c2 != 8'hFF) begin
                lastDiag = i_fmlr_partner.diagQ.pop_front();
                check(lastDiag.code, c2);
            end
            i_fmlr_partner.ack(r % 5);
            settle();
            check(latchedFaults, 19'h0_0000);
            check({faultLed, busFaultBit, relayOut, lampOut}, 4'h0);
        end
        $display("test code table done");
        check(histCount, 5'h10);
        histRdIdx <= 4'h0;
        settle();
        check(histRdData, lastDiag);
        histRdIdx <= 4'hF;
        settle();
        check(histRdValid, 1'b1);
        check(histRdData.code, 8'h07);
        $display("test history done");
        faultOutCfg <= 2'h1;
        fault(11, 1'b1);
        i_fmlr_partner.ack(0);
        settle();
        check(latchedFaults, 19'h0_0100);
        check({relayOut, lampOut}, 2'h2);
        cond <= '0;
        settle();
        check(latchedFaults, 19'h0_0100);
        mfAckCfg <= 3'h0;
        i_fmlr_partner.ack(2);
        settle();
        check(latchedFaults, 19'h0_0100);
        mfAckCfg <= 3'h7;
        faultOutCfg <= 2'h3;
        i_fmlr_partner.ack(3);
        settle();
        check(latchedFaults, 19'h0_0000);
        $display("test live ack and config done");
        diagSupported <= 1'b0;
        i_fmlr_partner.diagQ.delete();
        histRdIdx <= 4'h0;
        fault(14, 1'b0);
        check(i_fmlr_partner.diagQ.size(), 0);
        check(histRdData.code, 8'h0B);
        diagSupported <= 1'b1;
        i_fmlr_partner.ack(1);
        autoAckEn <= 1'b1;
        @(posedge clk) cond <= fmlr_pkg::fmlr_cond_t'(17'h0_0041);
        @(posedge clk) cond <= '0;
        settle();
        check(latchedFaults, 19'h0_4080);
        i_fmlr_partner.ack(0);
        autoAckEn <= 1'b0;
        settle();
        $display("test auto ack done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        check(histCount, 5'h00);
        check(secondsNow, 32'h0000_0000);
        check(histRdValid, 1'b0);
        check(histRdData, 40'h00_0000_0000);
        repeat (8) @(posedge clk);
        #1;
        check(secondsNow, 32'h0000_0000);
        @(posedge clk) #1;
        check(secondsNow, 32'h0000_0001);
        $display("test second reset done");
        test_done();
    end
endmodule
